// ### src/pco_core.sv
// position compare engine with target table and timed output pulses
`timescale 1ns/100ps
`include "pco_params.svh"

module pco_core #(
    parameter int NPTS  = 40,                    // number of target points
    parameter int UNITC = `PCO_UNIT_CYC          // clock cycles per 0.1 ms
) (
    input  wire logic        CLK_I,              // 20 MHz clock
    input  wire logic        SRST_I,             // synchronous reset, high
    input  wire logic        POS_VALID_I,        // encoder sample strobe
    input  wire logic [31:0] POS_DELTA_I,        // 32-bit signed count change since last sample
    input  wire logic [7:0]  ADDR_I,             // register word address
    input  wire logic [31:0] WDATA_I,            // write data
    input  wire logic        WR_I,               // write strobe
    input  wire logic        RD_I,               // read strobe
    output logic      [31:0] RDATA_O,            // read data, cycle after read
    output logic      [3:0]  DO_O                // compare output channels
);
    // ======================================================================
    // configuration registers
    logic [31:0]           val_r [NPTS];
    logic [15:0]           attr_r [NPTS];
    logic                  en_r;
    logic [2:0]            resol_r;
    pco_pkg::pco_mode_t    mode_r;
    logic [15:0]           width_r;
    logic [3:0]            pol_r;
    logic [5:0]            first_r;
    logic [5:0]            last_r;
    logic [5:0]            entry_r;
    logic [31:0]           zofs_r;
    logic [15:0]           cycles_r;
    logic [15:0]           cyc_done_r;
    // run state
    pco_pkg::pco_state_t   st_r;
    logic [5:0]            prog_r;               // 1-based awaited point, 0 idle
    logic                  entered_r;            // cyclic absolute entry passed
    logic signed [31:0]    live_r;
    logic signed [31:0]    prev_r;
    logic                  sampled_r;            // a fresh sample to compare
    logic [15:0]           units_r;
    logic [$clog2(UNITC+1)-1:0] tick_r;
    logic [3:0]            ch_r;

    logic wr_en_one;
    logic wr_en_zero;
    assign wr_en_one  = WR_I && ADDR_I == `PCO_ADDR_ENABLE && WDATA_I[0];
    assign wr_en_zero = WR_I && ADDR_I == `PCO_ADDR_ENABLE && !WDATA_I[0];

    // crossing of target t between samples a and b, honouring direction bits
    function automatic logic crossed(input logic signed [31:0] a,
                                     input logic signed [31:0] b,
                                     input logic signed [31:0] t,
                                     input logic [15:0] at);
        logic up;
        logic dn;
        up = at[`PCO_ATTR_UP]   && a < t && b >= t;
        dn = at[`PCO_ATTR_DOWN] && a > t && b <= t;
        return up || dn;
    endfunction

    // ======================================================================
    // point table writes
    always_ff @(posedge CLK_I)
    begin
        if (WR_I && ADDR_I >= `PCO_ADDR_VAL_BASE && ADDR_I < `PCO_ADDR_VAL_BASE + 8'(NPTS))
            val_r[6'(ADDR_I - `PCO_ADDR_VAL_BASE)] <= WDATA_I;
        if (WR_I && ADDR_I >= `PCO_ADDR_ATTR_BASE && ADDR_I < `PCO_ADDR_ATTR_BASE + 8'(NPTS))
            attr_r[6'(ADDR_I - `PCO_ADDR_ATTR_BASE)] <= WDATA_I[15:0];
    end

    // settings registers; enable bit also cleared by the engine
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            resol_r  <= `PCO_RST_RESOL;
            mode_r   <= pco_pkg::PCO_SINGLE_ABS;
            width_r  <= `PCO_RST_WIDTH;
            pol_r    <= `PCO_RST_POLARITY;
            first_r  <= `PCO_RST_INDEX;
            last_r   <= `PCO_RST_INDEX;
            entry_r  <= `PCO_RST_INDEX;
            zofs_r   <= 32'h0000_0000;
            cycles_r <= `PCO_RST_CYCLES;
        end
        else if (WR_I)
        begin
            unique case (ADDR_I)
                `PCO_ADDR_RESOL:    resol_r  <= WDATA_I[2:0];
                `PCO_ADDR_MODE:     mode_r   <= pco_pkg::pco_mode_t'(WDATA_I[1:0]);
                `PCO_ADDR_WIDTH:    width_r  <= WDATA_I[15:0] < `PCO_WIDTH_MIN ? `PCO_WIDTH_MIN :
                                                WDATA_I[15:0] > `PCO_WIDTH_MAX ? `PCO_WIDTH_MAX : WDATA_I[15:0];
                `PCO_ADDR_POLARITY: pol_r    <= WDATA_I[3:0];
                `PCO_ADDR_FIRST:    first_r  <= WDATA_I[5:0];
                `PCO_ADDR_LAST:     last_r   <= WDATA_I[5:0];
                `PCO_ADDR_ENTRY:    entry_r  <= WDATA_I[5:0];
                `PCO_ADDR_ZERO_OFS: zofs_r   <= WDATA_I;
                `PCO_ADDR_CYCLES:   cycles_r <= WDATA_I[15:0];
                default: ;
            endcase
        end
    end

    // ======================================================================
    // live position: scaled encoder delta, offset load and clears
    logic signed [31:0] step;
    assign step = $signed(POS_DELTA_I) >>> resol_r;
    logic hit;          // point reached this cycle
    logic hit_clr;      // incremental modes clear on every hit
    assign hit_clr = hit && (mode_r == pco_pkg::PCO_CYC_INC || mode_r == pco_pkg::PCO_FIX_INC);

    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            live_r    <= 32'h0000_0000;
            prev_r    <= 32'h0000_0000;
            sampled_r <= 1'b0;
        end
        // start from the zero offset on enable
        else if (wr_en_one && !en_r)
        begin
            live_r    <= zofs_r;
            prev_r    <= zofs_r;
            sampled_r <= 1'b0;
        end
        else if (hit_clr)
        begin
            live_r    <= 32'h0000_0000;
            prev_r    <= 32'h0000_0000;
            sampled_r <= 1'b0;
        end
        // count scaled by the resolution code
        else if (en_r && POS_VALID_I)
        begin
            prev_r    <= live_r;
            live_r    <= live_r + step;
            sampled_r <= 1'b1;
        end
        else
            sampled_r <= 1'b0;
    end

    // ======================================================================
    // combinational search for a crossed point
    logic       any_hit;
    logic [5:0] hit_idx;
    always_comb
    begin
        any_hit = 1'b0;
        hit_idx = prog_r;
        if (!entered_r || mode_r != pco_pkg::PCO_CYC_ABS)
        begin
            // only the awaited point, entry point first
            any_hit = prog_r != 6'h00 &&
                      crossed(prev_r, live_r, val_r[6'(prog_r - 6'h01)], attr_r[6'(prog_r - 6'h01)]);
        end
        else
        begin
            // any point in range, lowest index wins
            for (int i = NPTS - 1; i >= 0; i--)
                if (6'(i + 1) >= first_r && 6'(i + 1) <= last_r &&
                    crossed(prev_r, live_r, val_r[i], attr_r[i]))
                begin
                    any_hit = 1'b1;
                    hit_idx = 6'(i + 1);
                end
        end
    end
    assign hit = st_r == pco_pkg::PCO_RUN && sampled_r && any_hit;

    // ======================================================================
    // sequencing of points, enable and cycle count
    logic is_last;
    assign is_last = hit_idx == last_r;
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            en_r       <= 1'b0;
            prog_r     <= 6'h00;
            entered_r  <= 1'b0;
            cyc_done_r <= 16'h0000;
        end
        else if (wr_en_zero)
        begin
            en_r   <= 1'b0;
            prog_r <= 6'h00;
        end
        // rising edge of the switch starts comparison
        else if (wr_en_one && !en_r)
        begin
            en_r       <= 1'b1;
            cyc_done_r <= 16'h0000;
            entered_r  <= mode_r != pco_pkg::PCO_CYC_ABS;
            // progress shows the first awaited point
            prog_r     <= mode_r == pco_pkg::PCO_CYC_ABS ? entry_r : first_r;
        end
        else if (hit)
        begin
            if (!entered_r)
            begin
                entered_r <= 1'b1;
                prog_r    <= first_r;
            end
            // final point ends or restarts by mode
            else if (is_last)
            begin
                unique case (mode_r)
                    // single absolute turns off; live kept
                    pco_pkg::PCO_SINGLE_ABS:
                    begin
                        en_r   <= 1'b0;
                        prog_r <= 6'h00;
                    end
                    // stop after the set number of cycles
                    pco_pkg::PCO_FIX_INC:
                    begin
                        cyc_done_r <= cyc_done_r + 16'h0001;
                        if (cyc_done_r + 16'h0001 >= cycles_r)
                        begin
                            en_r   <= 1'b0;
                            prog_r <= 6'h00;
                        end
                        else
                            prog_r <= first_r;
                    end
                    default: prog_r <= first_r;
                endcase
            end
            else if (mode_r == pco_pkg::PCO_CYC_ABS)
                prog_r <= 6'(hit_idx + 6'h01);
            else
                prog_r <= prog_r + 6'h01;
        end
    end

    // ======================================================================
    // pulse timing in 0.1 ms units
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            st_r    <= pco_pkg::PCO_IDLE;
            units_r <= 16'h0000;
            tick_r  <= '0;
            ch_r    <= 4'h0;
        end
        else
        begin
            unique case (st_r)
                pco_pkg::PCO_IDLE:
                    if (en_r)
                        st_r <= pco_pkg::PCO_RUN;
                pco_pkg::PCO_RUN:
                    if (hit)
                    begin
                        // fire on the point's channels; entry crossing silent
                        // channel mask from attribute bits 8..11
                        ch_r    <= entered_r ? attr_r[6'(hit_idx - 6'h01)][`PCO_ATTR_CH_LSB +: 4] : 4'h0;
                        units_r <= width_r;
                        tick_r  <= '0;
                        st_r    <= entered_r ? pco_pkg::PCO_PULSE : pco_pkg::PCO_RUN;
                    end
                    else if (!en_r)
                        st_r <= pco_pkg::PCO_IDLE;
                pco_pkg::PCO_PULSE:
                begin
                    // hold for width units, counted by a divider
                    if (tick_r == ($bits(tick_r))'(UNITC - 1))
                    begin
                        tick_r  <= '0;
                        units_r <= units_r - 16'h0001;
                        if (units_r == 16'h0001)
                        begin
                            ch_r <= 4'h0;
                            st_r <= en_r ? pco_pkg::PCO_RUN : pco_pkg::PCO_IDLE;
                        end
                    end
                    else
                        tick_r <= tick_r + 1'b1;
                end
                default: st_r <= pco_pkg::PCO_IDLE;
            endcase
        end
    end

    // polarity: active level 1 when bit set
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
            DO_O <= ~`PCO_RST_POLARITY;
        else
            DO_O <= ~(ch_r ^ pol_r);
    end

    // ======================================================================
    // register read path
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
            RDATA_O <= 32'h0000_0000;
        else if (RD_I)
        begin
            if (ADDR_I >= `PCO_ADDR_VAL_BASE && ADDR_I < `PCO_ADDR_VAL_BASE + 8'(NPTS))
                RDATA_O <= val_r[6'(ADDR_I - `PCO_ADDR_VAL_BASE)];
            else if (ADDR_I >= `PCO_ADDR_ATTR_BASE && ADDR_I < `PCO_ADDR_ATTR_BASE + 8'(NPTS))
                RDATA_O <= {16'h0000, attr_r[6'(ADDR_I - `PCO_ADDR_ATTR_BASE)]};
            else
            begin
                unique case (ADDR_I)
                    `PCO_ADDR_ENABLE:   RDATA_O <= {31'h0, en_r};
                    `PCO_ADDR_RESOL:    RDATA_O <= {29'h0, resol_r};
                    `PCO_ADDR_MODE:     RDATA_O <= {30'h0, mode_r};
                    `PCO_ADDR_WIDTH:    RDATA_O <= {16'h0, width_r};
                    `PCO_ADDR_POLARITY: RDATA_O <= {28'h0, pol_r};
                    `PCO_ADDR_FIRST:    RDATA_O <= {26'h0, first_r};
                    `PCO_ADDR_LAST:     RDATA_O <= {26'h0, last_r};
                    `PCO_ADDR_PROGRESS: RDATA_O <= {26'h0, prog_r};
                    `PCO_ADDR_LIVE:     RDATA_O <= live_r;
                    `PCO_ADDR_ZERO_OFS: RDATA_O <= zofs_r;
                    `PCO_ADDR_CYCLES:   RDATA_O <= {16'h0, cycles_r};
                    `PCO_ADDR_ENTRY:    RDATA_O <= {26'h0, entry_r};
                    `PCO_ADDR_CYC_DONE: RDATA_O <= {16'h0, cyc_done_r};
                    default:            RDATA_O <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ======================================================================
    // checks
    property p_prog_start;
        @(posedge CLK_I) disable iff (SRST_I)
        (wr_en_one && !en_r && mode_r != pco_pkg::PCO_CYC_ABS) |=> (prog_r == $past(first_r));
    endproperty
    a_prog_start: assert property (p_prog_start) else $error("progress not at first point");

    property p_offset;
        @(posedge CLK_I) disable iff (SRST_I)
        (wr_en_one && !en_r) |=> (live_r == $past(zofs_r));
    endproperty
    a_offset: assert property (p_offset) else $error("live position not loaded");

    property p_stop;
        @(posedge CLK_I) disable iff (SRST_I)
        wr_en_zero |=> (!en_r && prog_r == 6'h00);
    endproperty
    a_stop: assert property (p_stop) else $error("disable did not clear");

    property p_no_hit_pulse;
        @(posedge CLK_I) disable iff (SRST_I)
        (st_r == pco_pkg::PCO_PULSE && $past(st_r) == pco_pkg::PCO_PULSE && !$past(WR_I)) |->
            ($stable(prog_r) && $stable(ch_r));
    endproperty
    a_no_hit_pulse: assert property (p_no_hit_pulse) else $error("compare during pulse");

    property p_single_end;
        @(posedge CLK_I) disable iff (SRST_I)
        (hit && entered_r && is_last && mode_r == pco_pkg::PCO_SINGLE_ABS && !WR_I) |=> (!en_r && prog_r == 6'h00);
    endproperty
    a_single_end: assert property (p_single_end) else $error("single mode did not stop");

    property p_inc_clear;
        @(posedge CLK_I) disable iff (SRST_I)
        (hit_clr && !WR_I) |=> (live_r == 32'h0000_0000);
    endproperty
    a_inc_clear: assert property (p_inc_clear) else $error("incremental clear missing");

    property p_cyc_wrap;
        @(posedge CLK_I) disable iff (SRST_I)
        (hit && entered_r && is_last && mode_r == pco_pkg::PCO_CYC_INC && !WR_I) |=>
            (en_r && prog_r == $past(first_r));
    endproperty
    a_cyc_wrap: assert property (p_cyc_wrap) else $error("cyclic wrap wrong");

    property p_pulse_start;
        @(posedge CLK_I) disable iff (SRST_I)
        (hit && entered_r) |=> ##1 (DO_O == ~($past(attr_r[6'(hit_idx - 6'h01)][11:8], 2) ^ pol_r));
    endproperty
    a_pulse_start: assert property (p_pulse_start) else $error("output level wrong");

endmodule // pco_core

// ### src/pco_params.svh
// constants for the position compare output block
`ifndef PCO_PARAMS_SVH
`define PCO_PARAMS_SVH
// ==========================================================================
// register map (word addresses on the plain register port)
`define PCO_ADDR_ENABLE     8'h00
`define PCO_ADDR_RESOL      8'h01
`define PCO_ADDR_MODE       8'h02
`define PCO_ADDR_WIDTH      8'h03
`define PCO_ADDR_POLARITY   8'h04
`define PCO_ADDR_FIRST      8'h05
`define PCO_ADDR_LAST       8'h06
`define PCO_ADDR_PROGRESS   8'h07
`define PCO_ADDR_LIVE       8'h08
`define PCO_ADDR_ZERO_OFS   8'h09
`define PCO_ADDR_CYCLES     8'h0a
`define PCO_ADDR_ENTRY      8'h0b
`define PCO_ADDR_CYC_DONE   8'h0c
`define PCO_ADDR_VAL_BASE   8'h40
`define PCO_ADDR_ATTR_BASE  8'h80
// ==========================================================================
// attribute fields
`define PCO_ATTR_UP         0
`define PCO_ATTR_DOWN       1
`define PCO_ATTR_CH_LSB     8
// ==========================================================================
// reset values
`define PCO_RST_WIDTH       16'h000a
`define PCO_RST_POLARITY    4'hf
`define PCO_RST_RESOL       3'h0
`define PCO_RST_CYCLES      16'h0001
`define PCO_RST_INDEX       6'h01
// ==========================================================================
// pulse width limits in 0.1 ms units
`define PCO_WIDTH_MIN       16'h0005
`define PCO_WIDTH_MAX       16'h04b0
// ==========================================================================
// timing: pulse width unit is 0.1 ms = 100000 ns
`define PCO_UNIT_NS         100000
`define PCO_CLK_NS          50
`define PCO_UNIT_CYC        (`PCO_UNIT_NS / `PCO_CLK_NS)
`endif

// ### src/pco_pkg.sv
// types for the position compare output block
package pco_pkg;
    typedef enum logic [1:0] {
        PCO_SINGLE_ABS = 2'h0,
        PCO_CYC_INC    = 2'h1,
        PCO_FIX_INC    = 2'h2,
        PCO_CYC_ABS    = 2'h3
    } pco_mode_t;
    typedef enum logic [2:0] {
        PCO_IDLE  = 3'h1,
        PCO_RUN   = 3'h2,
        PCO_PULSE = 3'h4
    } pco_state_t;
endpackage

// ### test/pco_ctrl_model.sv
// motion controller model that counts and times compare pulses
`timescale 1ns/100ps

// ==========================================================================
// pulse sampler on the four compare inputs
module pco_ctrl_model (
    input  wire logic       clk_i,  // drive clock
    input  wire logic [3:0] do_i,   // compare outputs of the drive
    input  wire logic [3:0] pol_i,  // active level per channel
    output int              n_o,    // finished pulses seen
    output logic      [3:0] ch_o,   // channels active in the last pulse
    output int              wid_o   // length of the last pulse in cycles
);
    logic [3:0] act;
    int         run = 0;
    int         cnt = 0;    // pulse counter behind n_o

    assign n_o = cnt;

    assign act = ~(do_i ^ pol_i);

    // a pulse is only counted once it ends, as a real input filter would
    always @(posedge clk_i)
    begin
        if (act != 4'h0)
        begin
            run  <= run + 1;
            ch_o <= act;
        end
        else if (run != 0)
        begin
            cnt   <= cnt + 1;
            wid_o <= run;
            run   <= 0;
        end
    end
endmodule // pco_ctrl_model

// ### test/tb.sv
// self-checking testbench for the position compare engine
`timescale 1ns/100ps
`include "pco_params.svh"

module tb;
    localparam int UC = 4;          // shortened cycles per 0.1 ms
    logic        CLK_I = 1'b0;
    logic        SRST_I = 1'b1;
    logic        POS_VALID_I = 1'b0;
    logic [31:0] POS_DELTA_I = 32'h0;
    logic [7:0]  ADDR_I = 8'h00;
    logic [31:0] WDATA_I = 32'h0;
    logic        WR_I = 1'b0;
    logic        RD_I = 1'b0;
    logic [31:0] RDATA_O;
    logic [3:0]  DO_O;
    logic [3:0]  pol = 4'hf;
    logic [3:0]  ch;
    int          np, wid, ep = 0;
    int          n_errors = 0;
    int          n_checks = 0;

    pco_core #(.NPTS(40), .UNITC(UC)) uut (.CLK_I(CLK_I), .SRST_I(SRST_I), .POS_VALID_I(POS_VALID_I),
        .POS_DELTA_I(POS_DELTA_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
        .RDATA_O(RDATA_O), .DO_O(DO_O));
    pco_ctrl_model ctl (.clk_i(CLK_I), .do_i(DO_O), .pol_i(pol), .n_o(np), .ch_o(ch), .wid_o(wid));

    // ======================================================================
    // clock and watchdog
    initial forever #25 CLK_I = ~CLK_I;
    initial
    begin
        repeat (20000) @(posedge CLK_I);
        n_errors++;
        final_report();
    end

    // ======================================================================
    // access tasks
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK_I);
        ADDR_I  <= a;
        WDATA_I <= d;
        WR_I    <= 1'b1;
        @(posedge CLK_I);
        WR_I    <= 1'b0;
    endtask
    // read data appears in the cycle after the strobe and holds until the next read
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge CLK_I);
        ADDR_I <= a;
        RD_I   <= 1'b1;
        @(posedge CLK_I);
        RD_I   <= 1'b0;
        @(negedge CLK_I);
        chk(RDATA_O, e);
    endtask
    // one encoder sample, then w cycles for any pulse to run out
    task automatic step(input logic [31:0] d, input int w);
        @(posedge CLK_I);
        POS_VALID_I <= 1'b1;
        POS_DELTA_I <= d;
        @(posedge CLK_I);
        POS_VALID_I <= 1'b0;
        repeat (w) @(posedge CLK_I);
    endtask
    task automatic pt(input int i, input logic [31:0] v, input logic [31:0] at);
        wr(`PCO_ADDR_VAL_BASE + 8'(i - 1), v);
        wr(`PCO_ADDR_ATTR_BASE + 8'(i - 1), at);
    endtask
    task automatic start(input logic [31:0] m, input logic [31:0] last);
        wr(`PCO_ADDR_MODE, m);
        wr(`PCO_ADDR_FIRST, 32'h1);
        wr(`PCO_ADDR_LAST, last);
        wr(`PCO_ADDR_ENABLE, 32'h1);
    endtask
    task automatic pulses(input int add, input logic [3:0] c);
        ep += add;
        chk(32'(np), 32'(ep));
        chk({28'h0, ch}, {28'h0, c});
    endtask
    task automatic final_report;
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ======================================================================
    // main sequence
    initial
    begin
        repeat (3) @(posedge CLK_I);
        SRST_I <= 1'b0;
        rd(`PCO_ADDR_WIDTH, 32'h0000000a);
        rd(`PCO_ADDR_POLARITY, 32'h0000000f);
        rd(`PCO_ADDR_CYCLES, 32'h00000001);
        rd(`PCO_ADDR_PROGRESS, 32'h0);
        rd(8'h20, 32'h0);
        chk({28'h0, DO_O}, 32'h0);
        wr(`PCO_ADDR_WIDTH, 32'd2000);
        rd(`PCO_ADDR_WIDTH, 32'd1200);
        wr(`PCO_ADDR_WIDTH, 32'd3);
        rd(`PCO_ADDR_WIDTH, 32'd5);
        // table is loaded before any enable, targets far from overflow
        pt(1, 32'd10, 32'h103);
        pt(2, 32'd30, 32'h201);
        pt(3, 32'd20, 32'h402);
        $display("test registers done");
        start(32'h0, 32'h3);
        rd(`PCO_ADDR_PROGRESS, 32'h1);
        rd(`PCO_ADDR_LIVE, 32'h0);
        step(32'd12, 30);
        pulses(1, 4'h1);
        chk(32'(wid), 32'(5 * UC));
        rd(`PCO_ADDR_PROGRESS, 32'h2);
        step(32'd25, 30);
        pulses(1, 4'h2);
        step(-32'sd20, 30);
        pulses(1, 4'h4);
        rd(`PCO_ADDR_PROGRESS, 32'h0);
        rd(`PCO_ADDR_LIVE, 32'd17);
        step(32'd10, 30);
        rd(`PCO_ADDR_LIVE, 32'd17);
        pulses(0, 4'h4);
        wr(`PCO_ADDR_ENABLE, 32'h0);
        $display("test single absolute done");
        wr(`PCO_ADDR_ZERO_OFS, 32'd100);
        wr(`PCO_ADDR_RESOL, 32'h7);
        start(32'h0, 32'h3);
        rd(`PCO_ADDR_LIVE, 32'd100);
        step(32'd1280, 2);
        rd(`PCO_ADDR_LIVE, 32'd110);
        wr(`PCO_ADDR_ENABLE, 32'h0);
        rd(`PCO_ADDR_PROGRESS, 32'h0);
        wr(`PCO_ADDR_ZERO_OFS, 32'h0);
        wr(`PCO_ADDR_RESOL, 32'h0);
        $display("test offset and resolution done");
        start(32'h1, 32'h2);
        step(32'd12, 30);
        rd(`PCO_ADDR_LIVE, 32'h0);
        step(32'd31, 30);
        pulses(2, 4'h2);
        rd(`PCO_ADDR_PROGRESS, 32'h1);
        // travel shorter than the pulse on purpose: second target is lost
        step(32'd12, 0);
        step(32'd31, 30);
        pulses(1, 4'h1);
        rd(`PCO_ADDR_PROGRESS, 32'h2);
        wr(`PCO_ADDR_ENABLE, 32'h0);
        $display("test cyclic incremental done");
        wr(`PCO_ADDR_CYCLES, 32'h2);
        start(32'h2, 32'h2);
        step(32'd12, 30);
        step(32'd31, 30);
        rd(`PCO_ADDR_PROGRESS, 32'h1);
        step(32'd12, 30);
        step(32'd31, 30);
        pulses(4, 4'h2);
        rd(`PCO_ADDR_PROGRESS, 32'h0);
        rd(`PCO_ADDR_CYC_DONE, 32'h2);
        wr(`PCO_ADDR_ENABLE, 32'h0);
        $display("test fixed cycles done");
        // ascending targets as cyclic absolute needs
        pt(2, 32'd20, 32'h201);
        pt(3, 32'd30, 32'h401);
        wr(`PCO_ADDR_ENTRY, 32'h2);
        start(32'h3, 32'h3);
        step(32'd12, 30);
        step(32'd10, 30);
        pulses(0, 4'h2);
        step(32'd10, 30);
        pulses(1, 4'h4);
        wr(`PCO_ADDR_ENABLE, 32'h0);
        $display("test cyclic absolute done");
        wr(`PCO_ADDR_POLARITY, 32'he);
        // the model follows one edge later, when the output register takes the new level
        @(posedge CLK_I);
        pol <= 4'he;
        repeat (3) @(posedge CLK_I);
        chk({28'h0, DO_O}, 32'h1);
        // channel 1 now pulses active low
        start(32'h0, 32'h1);
        step(32'd12, 5);
        @(negedge CLK_I);
        chk({28'h0, DO_O}, 32'h0);
        repeat (30) @(posedge CLK_I);
        pulses(1, 4'h1);
        $display("test polarity done");
        final_report();
    end
endmodule // tb
